/* File: rtl/syscfg_top.sv */
// system configuration registers, lock, clock, wait states, power modes
`timescale 1ns/1ns

module syscfg_top
  import syscfg_pkg::*;
#(
  parameter bit CLK_DIV4 = 1'b1,
  parameter bit LOWPWR_DISABLE = 1'b0
)(
  // clock and resets
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // register access
  input wire logic bus_pf_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_hit_o,
  // straps and mode pin
  input wire logic mp_mode_i,
  input wire logic mode_pin_level_i,
  input wire logic mode_pin_write_override_i,
  input wire logic nvm_write_override_i,
  // oscillator
  input wire logic osc_fault_i,
  input wire logic clk_valid_i,
  output logic reset_pin_out_o,
  output logic reset_pin_oe_o,
  output logic cpu_suspend_o,
  // external access
  input wire logic acc_start_i,
  input wire syscfg_acc_t acc_class_i,
  input wire logic wait_n_i,
  output logic acc_busy_o,
  output logic acc_done_o,
  // power modes
  input wire logic idle_exec_i,
  input wire logic wake_i,
  output logic cpu_stop_o,
  output logic module_clk_gate_o,
  output logic timer_clk_gate_o,
  output logic system_clock_tick_o,
  // control outputs
  output logic oscillator_low_drive_o,
  output logic memory_disable_o,
  output logic ext_int_nonmaskable_o,
  output logic bus_test_o,
  output logic cpu_test_o,
  output logic locked_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cold;
    logic osc_flt;
    logic osc_low;
    logic pf_wait;
    logic fast;
    logic memdis;
    logic halt_sel;
    logic pwrdn_sel;
    logic bus_tst;
    logic cpu_tst;
    logic nmi;
    logic lock;
    syscfg_pm_t pm;
    logic [1:0] div_cnt;
    logic [7:0] rdata;
  } syscfg_st_t;

  syscfg_st_t st_reg, st_next;

  logic [15:0] addr;
  logic sel0, sel1, sel2;
  logic [7:0] rd0, rd1, rd2;
  logic [7:0] m0, m1, m2;
  logic [7:0] wd;
  logic fault_evt;
  logic om_hold;

  // ----------------------------------------------------------------
  // oscillator monitor
  // ----------------------------------------------------------------
  syscfg_oscmon u_oscmon (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i | por_i),
    .osc_fault_i(osc_fault_i),
    // low drive turns fault detection off
    .monitor_en_i(~st_reg.osc_low),
    .clk_valid_i(clk_valid_i),
    .fault_evt_o(fault_evt),
    .reset_pin_out_o(reset_pin_out_o),
    .reset_pin_oe_o(reset_pin_oe_o),
    .hold_o(om_hold)
  );

  // ----------------------------------------------------------------
  // wait-state sequencer
  // ----------------------------------------------------------------
  syscfg_wait u_wait (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i | por_i),
    .pf_extra_wait_i(st_reg.pf_wait),
    .ext_fast_i(st_reg.fast),
    .acc_start_i(acc_start_i),
    .acc_class_i(acc_class_i),
    .wait_n_i(wait_n_i),
    .acc_busy_o(acc_busy_o),
    .acc_done_o(acc_done_o)
  );

  // ----------------------------------------------------------------
  // address decode and read data
  // ----------------------------------------------------------------
  // memory and peripheral number decode
  assign addr = bus_pf_i ? (PF_BASE | {8'h00, bus_addr_i[7:0]})
                         : bus_addr_i;

  always_comb begin
    sel0 = 1'b0;
    sel1 = 1'b0;
    sel2 = 1'b0;
    if (addr == SC0_ADDR) begin
      sel0 = 1'b1;
    end else if (addr == SC1_ADDR) begin
      sel1 = 1'b1;
    end else if (addr == SC2_ADDR) begin
      sel2 = 1'b1;
    end
  end

  assign bus_hit_o = sel0 | sel1 | sel2;

  always_comb begin
    rd0 = 8'h00;
    rd1 = 8'h00;
    rd2 = 8'h00;
    rd0[SC0_COLD] = st_reg.cold;
    rd0[SC0_OSCLOW] = st_reg.osc_low;
    rd0[SC0_PFWAIT] = st_reg.pf_wait;
    rd0[SC0_OSCFLT] = st_reg.osc_flt;
    rd0[SC0_MPWPO] = mode_pin_write_override_i;
    rd0[SC0_MPLVL] = mode_pin_level_i;
    rd0[SC0_MPMODE] = mp_mode_i;
    rd1[SC1_FAST] = st_reg.fast;
    rd1[SC1_MEMDIS] = st_reg.memdis;
    rd2[SC2_HALT] = st_reg.halt_sel;
    rd2[SC2_PWRDN] = st_reg.pwrdn_sel;
    rd2[SC2_BUSTST] = st_reg.bus_tst;
    rd2[SC2_CPUTST] = st_reg.cpu_tst;
    rd2[SC2_NMI] = st_reg.nmi;
    rd2[SC2_LOCK] = st_reg.lock;
  end

  // ----------------------------------------------------------------
  // write masks
  // ----------------------------------------------------------------
  // override input plays no part here
  // no watchdog bits live in this block
  assign m0 = st_reg.lock ? ~SC0_PROT : 8'hFF;
  assign m1 = st_reg.lock ? ~SC1_PROT : 8'hFF;
  assign m2 = st_reg.lock ? ~SC2_PROT : 8'hFF;
  assign wd = bus_wdata_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    if (bus_rd_i) begin
      st_next.rdata = sel0 ? rd0 : sel1 ? rd1 : sel2 ? rd2 : 8'h00;
    end

    if (bus_wr_i && sel0) begin
      st_next.cold = wd[SC0_COLD];
      st_next.osc_flt = wd[SC0_OSCFLT];
      if (m0[SC0_OSCLOW]) begin
        st_next.osc_low = wd[SC0_OSCLOW];
      end
      if (m0[SC0_PFWAIT]) begin
        st_next.pf_wait = wd[SC0_PFWAIT];
      end
    end
    // a fault in the clearing cycle still sets the flag
    if (fault_evt) begin
      st_next.osc_flt = 1'b1;
    end

    if (bus_wr_i && sel1) begin
      if (m1[SC1_FAST]) begin
        st_next.fast = wd[SC1_FAST];
      end
      if (m1[SC1_MEMDIS]) begin
        st_next.memdis = wd[SC1_MEMDIS];
      end
    end

    if (bus_wr_i && sel2 && !st_reg.lock) begin
      // mode bits frozen when low power is disabled
      if (!LOWPWR_DISABLE) begin
        st_next.halt_sel = wd[SC2_HALT];
        st_next.pwrdn_sel = wd[SC2_PWRDN];
      end
      st_next.bus_tst = wd[SC2_BUSTST];
      st_next.cpu_tst = wd[SC2_CPUTST];
      st_next.nmi = wd[SC2_NMI];
      st_next.lock = wd[SC2_LOCK];
    end

    // system clock tick from build option
    if (CLK_DIV4) begin
      st_next.div_cnt = st_reg.div_cnt + 2'h1;
    end

    case (st_reg.pm)
      PM_RUN: begin
        if (idle_exec_i) begin
          if (LOWPWR_DISABLE || !st_reg.pwrdn_sel) begin
            st_next.pm = PM_IDLE;
          end else if (st_reg.halt_sel) begin
            st_next.pm = PM_HALT;
          end else begin
            st_next.pm = PM_STANDBY;
          end
        end
      end
      PM_IDLE, PM_STANDBY: begin
        if (wake_i) begin
          st_next.pm = PM_RUN;
        end
      end
      PM_HALT: begin
        if (wake_i) begin
          st_next.pm = PM_RESUME;
        end
      end
      PM_RESUME: begin
        // restart only on a valid clock
        if (clk_valid_i) begin
          st_next.pm = PM_RUN;
        end
      end
      default: begin
        st_next.pm = PM_RUN;
      end
    endcase

    if (rst_i || por_i) begin
      st_next.osc_low = 1'b0;
      st_next.pf_wait = 1'b0;
      st_next.fast = 1'b0;
      st_next.memdis = mp_mode_i;
      st_next.halt_sel = 1'b0;
      st_next.pwrdn_sel = 1'b0;
      st_next.bus_tst = 1'b0;
      st_next.cpu_tst = SC2_CPUTST_RST;
      st_next.nmi = 1'b0;
      st_next.lock = 1'b0;
      st_next.pm = PM_RUN;
      st_next.div_cnt = 2'h0;
      st_next.rdata = 8'h00;
    end
    if (por_i) begin
      st_next.cold = 1'b1;
      st_next.osc_flt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // processor stops in any idle state
  assign cpu_stop_o = st_reg.pm != PM_RUN;
  // standby gates all but the first timer
  assign module_clk_gate_o = st_reg.pm == PM_STANDBY ||
                             st_reg.pm == PM_HALT ||
                             st_reg.pm == PM_RESUME;
  // halt also stops the first timer
  assign timer_clk_gate_o = st_reg.pm == PM_HALT ||
                            st_reg.pm == PM_RESUME;
  assign cpu_suspend_o = om_hold || st_reg.pm == PM_RESUME;
  assign system_clock_tick_o = !CLK_DIV4 ||
                               st_reg.div_cnt == CLK_DIV4_LAST;

  assign bus_rdata_o = st_reg.rdata;
  assign oscillator_low_drive_o = st_reg.osc_low;
  assign memory_disable_o = st_reg.memdis;
  assign ext_int_nonmaskable_o = st_reg.nmi;
  assign bus_test_o = st_reg.bus_tst;
  assign cpu_test_o = st_reg.cpu_tst;
  assign locked_o = st_reg.lock;

endmodule

/* File: rtl/syscfg_pkg.sv */
// shared constants and types of the system configuration block
package syscfg_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] SC0_ADDR = 16'h1010;
  localparam logic [15:0] SC1_ADDR = 16'h1011;
  localparam logic [15:0] SC2_ADDR = 16'h1012;
  // peripheral-file number n maps to byte address base | n
  localparam logic [15:0] PF_BASE = 16'h1000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SC0_COLD = 7;
  localparam int SC0_OSCLOW = 6;
  localparam int SC0_PFWAIT = 5;
  localparam int SC0_OSCFLT = 4;
  localparam int SC0_MPWPO = 3;
  localparam int SC0_MPLVL = 2;
  localparam int SC0_MPMODE = 0;
  localparam int SC1_FAST = 4;
  localparam int SC1_MEMDIS = 2;
  localparam int SC2_HALT = 7;
  localparam int SC2_PWRDN = 6;
  localparam int SC2_BUSTST = 4;
  localparam int SC2_CPUTST = 3;
  localparam int SC2_NMI = 1;
  localparam int SC2_LOCK = 0;

  // bits frozen once the lock is set
  localparam logic [7:0] SC0_PROT = 8'h60;
  localparam logic [7:0] SC1_PROT = 8'h14;
  localparam logic [7:0] SC2_PROT = 8'hDB;

  // ----------------------------------------------------------------
  // reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic SC2_CPUTST_RST = 1'b1;
  localparam logic [3:0] OSC_RST_HOLD_CYC = 4'h8;
  localparam logic [2:0] INT_ACC_CYC = 3'h1;
  localparam logic [2:0] EXT_FAST_CYC = 3'h2;
  localparam logic [2:0] EXT_SLOW_CYC = 3'h3;
  localparam logic [2:0] PF_WAIT_CYC = 3'h4;
  localparam logic [1:0] CLK_DIV4_LAST = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PM_RUN = 3'b000,
    PM_IDLE = 3'b001,
    PM_STANDBY = 3'b010,
    PM_HALT = 3'b011,
    PM_RESUME = 3'b100
  } syscfg_pm_t;

  typedef enum logic [1:0] {
    ACC_INT = 2'b00,
    ACC_EXT_MEM = 2'b01,
    ACC_EXT_PF = 2'b10
  } syscfg_acc_t;

endpackage

/* File: rtl/syscfg_oscmon.sv */
// oscillator fault reset stretcher and clock-valid hold
`timescale 1ns/1ns
module syscfg_oscmon
  import syscfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // monitor
  input wire logic osc_fault_i,
  input wire logic monitor_en_i,
  input wire logic clk_valid_i,
  // results
  output logic fault_evt_o,
  output logic reset_pin_out_o,
  output logic reset_pin_oe_o,
  output logic hold_o
);

  typedef struct packed {
    logic fault_prev;
    logic [3:0] cnt;
    logic drive;
    logic hold;
  } syscfg_om_t;

  syscfg_om_t st_reg, st_next;
  logic evt;

  always_comb begin
    st_next = st_reg;
    evt = osc_fault_i & monitor_en_i & ~st_reg.fault_prev;
    st_next.fault_prev = osc_fault_i & monitor_en_i;
    if (evt) begin
      st_next.cnt = OSC_RST_HOLD_CYC;
      st_next.drive = 1'b1;
    end else if (st_reg.cnt != 4'h0) begin
      st_next.cnt = st_reg.cnt - 4'h1;
      st_next.drive = (st_reg.cnt != 4'h1);
    end
    st_next.hold = st_next.drive | ~clk_valid_i;
    if (rst_i) begin
      st_next = '0;
      st_next.hold = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st_reg <= st_next;
  end

  // the pin is open drain: it only ever pulls low
  assign fault_evt_o = evt & ~rst_i;
  assign reset_pin_out_o = 1'b0;
  assign reset_pin_oe_o = st_reg.drive;
  assign hold_o = st_reg.hold;

endmodule

/* File: rtl/syscfg_wait.sv */
// bus access length sequencer with external wait input
`timescale 1ns/1ns
module syscfg_wait
  import syscfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // wait-state settings
  input wire logic pf_extra_wait_i,
  input wire logic ext_fast_i,
  // access
  input wire logic acc_start_i,
  input wire syscfg_acc_t acc_class_i,
  input wire logic wait_n_i,
  output logic acc_busy_o,
  output logic acc_done_o
);

  typedef struct packed {
    logic busy;
    logic [2:0] cnt;
    logic [2:0] last;
  } syscfg_ws_t;

  syscfg_ws_t st_reg, st_next;
  logic [2:0] len;
  logic fin;

  always_comb begin
    st_next = st_reg;
    len = ext_fast_i ? EXT_FAST_CYC : EXT_SLOW_CYC;
    if (acc_class_i == ACC_EXT_PF && pf_extra_wait_i) begin
      len = PF_WAIT_CYC;
    end else if (acc_class_i == ACC_INT) begin
      len = INT_ACC_CYC;
    end
    fin = st_reg.busy & (st_reg.cnt == st_reg.last) & wait_n_i;
    if (st_reg.busy) begin
      if (fin) begin
        st_next.busy = 1'b0;
      end else if (st_reg.cnt != st_reg.last) begin
        st_next.cnt = st_reg.cnt + 3'h1;
      end
    end else if (acc_start_i && acc_class_i != ACC_INT) begin
      st_next.busy = 1'b1;
      st_next.cnt = 3'h1;
      st_next.last = len - 3'h1;
    end
    if (rst_i) begin
      st_next = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st_reg <= st_next;
  end

  // internal accesses finish in their start cycle
  assign acc_done_o = fin |
    (~st_reg.busy & acc_start_i & acc_class_i == ACC_INT);
  assign acc_busy_o = st_reg.busy;

endmodule

/* File: sim/syscfg_sva.sv */
// concurrent assertions for the system configuration block
`timescale 1ns/1ns
module syscfg_sva
  import syscfg_pkg::*;
#(
  parameter bit CLK_DIV4 = 1'b1
)(
  // clock and resets
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // register bus
  input wire logic bus_pf_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_wdata_i,
  // oscillator
  input wire logic osc_fault_i,
  input wire logic clk_valid_i,
  input wire logic reset_pin_oe_o,
  input wire logic cpu_suspend_o,
  // access sequencer
  input wire logic acc_start_i,
  input wire syscfg_acc_t acc_class_i,
  input wire logic wait_n_i,
  input wire logic acc_busy_o,
  input wire logic acc_done_o,
  // power and control
  input wire logic idle_exec_i,
  input wire logic cpu_stop_o,
  input wire logic module_clk_gate_o,
  input wire logic timer_clk_gate_o,
  input wire logic system_clock_tick_o,
  input wire logic oscillator_low_drive_o,
  input wire logic locked_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i || por_i);
  logic wr0, wr2, go;
  assign wr0 = bus_wr_i && !bus_pf_i && bus_addr_i == SC0_ADDR;
  assign wr2 = bus_wr_i && !bus_pf_i && bus_addr_i == SC2_ADDR;
  assign go = acc_start_i && !acc_busy_o;
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  sequence s_fault; $rose(osc_fault_i) && !oscillator_low_drive_o; endsequence
  sequence s_stretch; reset_pin_oe_o [*8]; endsequence
  sequence s_gap; !system_clock_tick_o [*3] ##1 system_clock_tick_o; endsequence
  property p_lock_set; wr2 && bus_wdata_i[SC2_LOCK] |=> locked_o; endproperty
  property p_lock_keep; locked_o |=> locked_o; endproperty
  property p_prot0; locked_o && wr0 |=> $stable(oscillator_low_drive_o);
  endproperty
  property p_osc_pulse; s_fault |=> s_stretch; endproperty
  property p_suspend;
    reset_pin_oe_o || !clk_valid_i && !$past(clk_valid_i) |-> cpu_suspend_o;
  endproperty
  property p_ext_min;
    go && acc_class_i != ACC_INT |-> !acc_done_o ##1 acc_busy_o;
  endproperty
  property p_int; go && acc_class_i == ACC_INT |-> acc_done_o ##1 !acc_busy_o;
  endproperty
  property p_wait; acc_done_o && acc_busy_o |-> wait_n_i; endproperty
  property p_idle; idle_exec_i && !cpu_stop_o |=> cpu_stop_o; endproperty
  property p_halt; timer_clk_gate_o |-> module_clk_gate_o && cpu_stop_o;
  endproperty
  property p_tick; CLK_DIV4 && system_clock_tick_o |=> s_gap; endproperty
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_lock_set: assert property (p_lock_set)
    else $error("lock bit write did not lock");
  a_lock_keep: assert property (p_lock_keep)
    else $error("lock dropped without reset");
  a_prot0: assert property (p_prot0)
    else $error("protected drive bit changed while locked");
  a_osc_pulse: assert property (p_osc_pulse)
    else $error("reset pin pull shorter than eight cycles");
  a_suspend: assert property (p_suspend)
    else $error("operation not suspended");
  a_ext_min: assert property (p_ext_min)
    else $error("external access too short");
  a_int: assert property (p_int)
    else $error("internal access not single cycle");
  a_wait: assert property (p_wait)
    else $error("access ended while wait held low");
  a_idle: assert property (p_idle)
    else $error("idle instruction did not stop the processor");
  a_halt: assert property (p_halt)
    else $error("halt without all clocks gated");
  a_tick: assert property (p_tick)
    else $error("system clock tick not one in four");
endmodule

bind syscfg_top syscfg_sva #(.CLK_DIV4(CLK_DIV4)) i_syscfg_sva (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .por_i(por_i),
  .bus_pf_i(bus_pf_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
  .bus_wdata_i(bus_wdata_i), .osc_fault_i(osc_fault_i),
  .clk_valid_i(clk_valid_i), .reset_pin_oe_o(reset_pin_oe_o),
  .cpu_suspend_o(cpu_suspend_o), .acc_start_i(acc_start_i),
  .acc_class_i(acc_class_i), .wait_n_i(wait_n_i), .acc_busy_o(acc_busy_o),
  .acc_done_o(acc_done_o), .idle_exec_i(idle_exec_i),
  .cpu_stop_o(cpu_stop_o), .module_clk_gate_o(module_clk_gate_o),
  .timer_clk_gate_o(timer_clk_gate_o),
  .system_clock_tick_o(system_clock_tick_o),
  .oscillator_low_drive_o(oscillator_low_drive_o), .locked_o(locked_o));

/* File: sim/syscfg_ext_model.sv */
// external memory and peripheral model that drives the wait line
`timescale 1ns/1ns
module syscfg_ext_model
  import syscfg_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // access seen on the bus
  input wire logic acc_start_i,
  input wire syscfg_acc_t acc_class_i,
  input wire logic acc_busy_o,
  // commanded behaviour
  input wire logic [3:0] stall_i,
  input wire logic hold_i,
  // wait line
  output logic wait_n_o
);
  logic [3:0] cnt = 4'h0;
  always @(posedge core_clk_i) begin
    if (acc_start_i && !acc_busy_o && acc_class_i != ACC_INT) begin
      cnt <= stall_i;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // line is pulled up when no device stretches; hold_i misbehaves on purpose
  assign wait_n_o = (cnt == 4'h0) && !hold_i;
endmodule

/* File: sim/tb_top.sv */
// self-checking testbench for the system configuration block
`timescale 1ns/1ns
module tb_top;
  import syscfg_pkg::*;
  logic core_clk_i, rst_i, por_i, bus_pf_i, bus_wr_i, bus_rd_i, hold;
  logic [15:0] bus_addr_i;
  logic [7:0] bus_wdata_i, bus_rdata_o, q[$], lat_q[$];
  logic osc_fault_i, clk_valid_i, reset_pin_oe_o, cpu_suspend_o, wait_n_i;
  logic acc_start_i, acc_busy_o, acc_done_o, idle_exec_i, wake_i;
  logic rd_pend = 1'b0;
  logic hit, rpo, osclow, memdis, nmi, bustst, cputst;
  logic cpu_stop_o, module_clk_gate_o, timer_clk_gate_o, tick, locked_o;
  logic nvm_ovr;
  logic [3:0] stall;
  syscfg_acc_t acc_class_i;
  int fail_count, total_checks, done_cnt, k, s;
  time t_start;
  // ----------------------------------------------------------------
  // design, partner and clock
  // ----------------------------------------------------------------
  syscfg_top #(.CLK_DIV4(1'b1), .LOWPWR_DISABLE(1'b0)) i_syscfg_top (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .por_i(por_i),
    .bus_pf_i(bus_pf_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .bus_hit_o(hit), .mp_mode_i(1'b0),
    .mode_pin_level_i(1'b1), .mode_pin_write_override_i(1'b0),
    .nvm_write_override_i(nvm_ovr), .osc_fault_i(osc_fault_i),
    .clk_valid_i(clk_valid_i), .reset_pin_out_o(rpo),
    .reset_pin_oe_o(reset_pin_oe_o), .cpu_suspend_o(cpu_suspend_o),
    .acc_start_i(acc_start_i), .acc_class_i(acc_class_i),
    .wait_n_i(wait_n_i), .acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o),
    .idle_exec_i(idle_exec_i), .wake_i(wake_i), .cpu_stop_o(cpu_stop_o),
    .module_clk_gate_o(module_clk_gate_o),
    .timer_clk_gate_o(timer_clk_gate_o), .system_clock_tick_o(tick),
    .oscillator_low_drive_o(osclow), .memory_disable_o(memdis),
    .ext_int_nonmaskable_o(nmi), .bus_test_o(bustst), .cpu_test_o(cputst),
    .locked_o(locked_o));
  syscfg_ext_model i_syscfg_ext_model (
    .core_clk_i(core_clk_i), .acc_start_i(acc_start_i),
    .acc_class_i(acc_class_i), .acc_busy_o(acc_busy_o),
    .stall_i(stall), .hold_i(hold), .wait_n_o(wait_n_i));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------------------------------
  // tasks and result watcher
  // ----------------------------------------------------------------
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(logic p, logic [15:0] a, logic [7:0] d);
    bus_pf_i = p;
    bus_addr_i = a;
    bus_wdata_i = d;
    bus_wr_i = 1'b1;
    step(1);
    bus_wr_i = 1'b0;
    step(1);
  endtask
  task automatic rd(logic p, logic [15:0] a, logic [7:0] e);
    q.push_back(e);
    bus_pf_i = p;
    bus_addr_i = a;
    bus_rd_i = 1'b1;
    step(1);
    bus_rd_i = 1'b0;
    step(1);
  endtask
  task automatic acc(syscfg_acc_t c, logic [7:0] e);
    int n;
    n = done_cnt;
    lat_q.push_back(e);
    t_start = $time + 39;
    acc_class_i = c;
    acc_start_i = 1'b1;
    step(1);
    acc_start_i = 1'b0;
    for (int i = 0; i < 30 && done_cnt == n; i++) step(1);
    if (done_cnt == n) begin
      chk("access done", 8'h01, 8'h00);
      complete_run();
    end
    step(1);
  endtask
  always @(posedge core_clk_i) begin
    if (rd_pend) chk("read data", q.pop_front(), bus_rdata_o);
    rd_pend <= bus_rd_i;
    if (acc_done_o === 1'b1) begin
      chk("latency", lat_q.pop_front(), 8'((($time - t_start) / 40)));
      done_cnt++;
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fail_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, por_i, clk_valid_i} = 3'h7;
    {bus_pf_i, bus_wr_i, bus_rd_i, osc_fault_i, hold, nvm_ovr} = 6'h00;
    {acc_start_i, idle_exec_i, wake_i} = 3'h0;
    bus_addr_i = 16'h0000;
    bus_wdata_i = 8'h00;
    stall = 4'h0;
    acc_class_i = ACC_INT;
    s = $urandom(67066);
    step(4);
    {rst_i, por_i} = 2'h0;
    rd(1'b0, SC0_ADDR, 8'h84);
    rd(1'b1, 16'h0011, 8'h00);
    rd(1'b1, 16'h0012, 8'h08);
    chk("hit", 8'h01, 8'(hit));
    wr(1'b0, 16'h1013, 8'hFF);
    chk("hit", 8'h00, 8'(hit));
    rd(1'b0, 16'h1013, 8'h00);
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      wr(1'b1, 16'h0010, {2'h0, m[1], 5'h00});
      wr(1'b0, SC1_ADDR, {3'h0, m[0], 4'h0});
      acc(ACC_EXT_MEM, m[0] ? 8'h01 : 8'h02);
      acc(ACC_EXT_PF, m[1] ? 8'h03 : (m[0] ? 8'h01 : 8'h02));
      acc(ACC_INT, 8'h00);
    end
    stall = 4'($urandom_range(6, 2));
    acc(ACC_EXT_MEM, 8'(stall) + 8'h01);
    stall = 4'h0;
    hold = 1'b1;
    acc(ACC_INT, 8'h00);
    hold = 1'b0;
    $display("test wait states done");
    osc_fault_i = 1'b1;
    clk_valid_i = 1'b0;
    k = 0;
    for (int i = 0; i < 20; i++) begin
      if (reset_pin_oe_o === 1'b1) k++;
      if (i == 2) chk("suspend", 8'h01, 8'(cpu_suspend_o));
      if (i == 2) chk("reset pin level", 8'h00, 8'(rpo));
      step(1);
    end
    chk("reset pin cycles", 8'h08, 8'(k));
    {osc_fault_i, clk_valid_i} = 2'h1;
    rd(1'b0, SC0_ADDR, 8'h34);
    rst_i = 1'b1;
    step(1);
    rst_i = 1'b0;
    rd(1'b0, SC0_ADDR, 8'h14);
    $display("test oscillator fault done");
    for (int m = 0; m < 4; m++) begin
      wr(1'b0, SC2_ADDR, {m[1], m[0], 6'h08});
      idle_exec_i = 1'b1;
      step(1);
      idle_exec_i = 1'b0;
      chk("stop", 8'h01, 8'(cpu_stop_o));
      chk("module gate", 8'(m[0]), 8'(module_clk_gate_o));
      chk("timer gate", 8'(m[0] & m[1]), 8'(timer_clk_gate_o));
      wake_i = 1'b1;
      step(1);
      wake_i = 1'b0;
      for (int i = 0; i < 8 && cpu_stop_o !== 1'b0; i++) step(1);
      chk("running", 8'h00, 8'(cpu_stop_o));
    end
    $display("test power modes done");
    wr(1'b0, SC0_ADDR, 8'h60);
    wr(1'b0, SC1_ADDR, 8'h14);
    wr(1'b0, SC2_ADDR, 8'h1B);
    chk("locked", 8'h01, 8'(locked_o));
    chk("controls", 8'h1F, {3'h0, osclow, memdis, nmi, bustst, cputst});
    nvm_ovr = 1'b1;
    wr(1'b0, SC0_ADDR, 8'h00);
    wr(1'b1, 16'h0011, 8'h00);
    wr(1'b0, SC2_ADDR, 8'hF6);
    rd(1'b0, SC0_ADDR, 8'h64);
    rd(1'b0, SC1_ADDR, 8'h14);
    rd(1'b0, SC2_ADDR, 8'h1B);
    nvm_ovr = 1'b0;
    rst_i = 1'b1;
    step(1);
    rst_i = 1'b0;
    chk("unlocked", 8'h00, 8'(locked_o));
    rd(1'b0, SC2_ADDR, 8'h08);
    $display("test lock done");
    k = 0;
    for (int i = 0; i < 40; i++) begin
      if (tick === 1'b1) k++;
      step(1);
    end
    chk("ticks", 8'h0A, 8'(k));
    $display("test clock divider done");
    complete_run();
  end
endmodule
